/* File: cpmbt_regs.svh */
// Register offsets, field positions, reset values and timing counts.
`ifndef CPMBT_REGS_SVH
`define CPMBT_REGS_SVH

`define CPMBT_OFF_CTRL0     8'h00
`define CPMBT_OFF_CTRL1     8'h04
`define CPMBT_OFF_BTIM0     8'h08
`define CPMBT_OFF_BTIM1     8'h0c
`define CPMBT_OFF_STATUS    8'h10

`define CPMBT_C0_SLEEP_REQUEST      0
`define CPMBT_C0_SOFTRST    1
`define CPMBT_C0_TLINK      2
`define CPMBT_C1_WUFILT     0
`define CPMBT_C1_CLKSEL     1
`define CPMBT_B0_PRESC_LO   0
`define CPMBT_B0_PRESC_HI   5
`define CPMBT_B0_SJW_LO     6
`define CPMBT_B0_SJW_HI     7
`define CPMBT_B1_TIME_SEGMENT_ONE_LO   0
`define CPMBT_B1_TIME_SEGMENT_ONE_HI   3
`define CPMBT_B1_TIME_SEGMENT_TWO_LO   4
`define CPMBT_B1_TIME_SEGMENT_TWO_HI   6
`define CPMBT_B1_SAMP3      7
`define CPMBT_ST_ACK        0
`define CPMBT_ST_MODE_LO    1
`define CPMBT_ST_MODE_HI    6
`define CPMBT_ST_GRP_LO     8
`define CPMBT_ST_GRP_HI     14

`define CPMBT_RST_SOFTRST   1'b1
`define CPMBT_RST_PRESC     6'h00
`define CPMBT_RST_SJW       2'h0
`define CPMBT_RST_TIME_SEGMENT_ONE     4'h3
`define CPMBT_RST_TIME_SEGMENT_TWO     3'h1

`define CPMBT_SYNC_BITS     4'hb
`define CPMBT_BUSOFF_GRPS   7'h7f
`define CPMBT_CORE_MHZ      40
`define CPMBT_FILT_NS       2000
`define CPMBT_FILT_CYC      ((`CPMBT_FILT_NS * `CPMBT_CORE_MHZ + 999) / 1000)

`endif

/* File: cpmbt_pkg.sv */
// Types shared by the mode control and bit timing block.
package cpmbt_pkg;

    typedef enum logic [5:0]
    {
        MODE_NORMAL = 6'b000001,
        MODE_SLPPND = 6'b000010,
        MODE_SLEEP  = 6'b000100,
        MODE_SOFTRS = 6'b001000,
        MODE_PWRDN  = 6'b010000,
        MODE_RESYNC = 6'b100000
    } cpmbt_mode_e;

    typedef struct packed
    {
        logic       busTx;
        logic       timerCap;
        logic       engRun;
        logic       engAbort;
        logic       wakeReq;
        logic       deferGo;
        logic       busOffDone;
        logic       sampleTick;
        logic       rxBit;
        logic       txPoint;
    } cpmbt_eng_s;

    typedef struct packed
    {
        cpmbt_mode_e mode;
        logic        sleep_request;
        logic        soft_reset_lock;
        logic        tlnk;
        logic        wufs;
        logic        clkSel;
        logic [5:0]  presc;
        logic [1:0]  resync_jump_width;
        logic [3:0]  time_segment_one;
        logic [2:0]  time_segment_two;
        logic        samp3;
        logic [5:0]  preCnt;
        logic [4:0]  tqCnt;
        logic        rxPrev;
        logic        resyncUsed;
        logic [1:0]  smp;
        logic [3:0]  recCnt;
        logic [3:0]  boBits;
        logic [6:0]  boGrp;
        logic [7:0]  filtCnt;
        logic        pulseOn;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
        cpmbt_eng_s  eng;
    } cpmbt_state_s;

endpackage

/* File: cpmbt_top.sv */
// Mode control, wake-up, timer link and bit timing for a CAN controller.
`include "cpmbt_regs.svh"

// Function
// - Sleep request clear ignored until acknowledged
// - Eleven recessive bits before joining traffic
// - Deferred actions run on wake-up
// - Bus-off recessive group count resumes
// - Soft reset halts protocol, registers accessible
// - Soft reset abandons frames immediately
// - CPU stop forces immediate power-down
// - Transmit pin recessive while powered down
// - No register access while powered down
// - Bus activity wakes; resync before data
// - Stays active during CPU wait
// - Optional glitch filter on sleep wake
// - Timer pulse from valid frame to next bit end
// - Timer pulse gated by link enable
// - Clock select picks oscillator or PLL
// - Prescaler divides clock into quanta
// - Sync segment is one quantum
// - Segment one is 4 to 16 quanta
// - Segment two is 2 to 8 quanta
// - Jump width is 1 to 4 quanta
// - Sample at segment boundary, third sample
// - Sleep waits for bus traffic to finish
// - Wake on activity, request clear, reset
module cpmbt_top
    import cpmbt_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        cpuStop,
    input  wire logic        xtalTick,
    input  wire logic        pllTick,
    input  wire logic        bus_receive_pin,
    output logic             bus_transmit_pin,
    input  wire logic        engTxBit,
    input  wire logic        engBusy,
    input  wire logic        engTxPending,
    input  wire logic        engFrameValid,
    input  wire logic        engBusOff,
    output logic             engRun,
    output logic             engAbort,
    output logic             engSampleTick,
    output logic             engRxBit,
    output logic             engTxPoint,
    output logic             engDeferGo,
    output logic             engBusOffDone,
    output logic             wakeReq,
    output logic             timerCapture
);

    cpmbt_state_s q;
    cpmbt_state_s d;

    logic       access;
    logic       wrEn;
    logic       pwrDown;
    logic       tqRun;
    logic       srcTick;
    logic       tq;
    logic [4:0] seg1End;
    logic [4:0] lastIdx;
    logic [4:0] sjwLen;
    logic [4:0] rem;
    logic       rxDom;
    logic       wakeDet;
    logic       edgeSeen;
    logic       bitVal;
    logic       bitEnd;
    logic [1:0] vote;

    always_comb
    begin
        d = q;
        d.eng.engAbort = 1'b0;
        d.eng.deferGo = 1'b0;
        d.eng.busOffDone = 1'b0;
        d.eng.sampleTick = 1'b0;
        d.eng.txPoint = 1'b0;
        d.eng.wakeReq = 1'b0;
        pwrDown = (q.mode == MODE_PWRDN);
        rxDom = ~bus_receive_pin;

        // APB slave with one wait state.
        access = psel & penable;
        d.pready = access & ~q.pready;
        d.pslverr = access & ~q.pready & pwrDown;
        wrEn = access & q.pready & pwrite & ~pwrDown;
        if (access & ~q.pready)
        begin
            d.prdata = 32'h0;
            if (!pwrDown)
            begin
                case (paddr)
                    `CPMBT_OFF_CTRL0:
                    begin
                        d.prdata[`CPMBT_C0_SLEEP_REQUEST] = q.sleep_request;
                        d.prdata[`CPMBT_C0_SOFTRST] = q.soft_reset_lock;
                        d.prdata[`CPMBT_C0_TLINK] = q.tlnk;
                    end
                    `CPMBT_OFF_CTRL1:
                    begin
                        d.prdata[`CPMBT_C1_WUFILT] = q.wufs;
                        d.prdata[`CPMBT_C1_CLKSEL] = q.clkSel;
                    end
                    `CPMBT_OFF_BTIM0:
                    begin
                        d.prdata[`CPMBT_B0_PRESC_HI:`CPMBT_B0_PRESC_LO] =
                            q.presc;
                        d.prdata[`CPMBT_B0_SJW_HI:`CPMBT_B0_SJW_LO] = q.resync_jump_width;
                    end
                    `CPMBT_OFF_BTIM1:
                    begin
                        d.prdata[`CPMBT_B1_TIME_SEGMENT_ONE_HI:`CPMBT_B1_TIME_SEGMENT_ONE_LO] =
                            q.time_segment_one;
                        d.prdata[`CPMBT_B1_TIME_SEGMENT_TWO_HI:`CPMBT_B1_TIME_SEGMENT_TWO_LO] =
                            q.time_segment_two;
                        d.prdata[`CPMBT_B1_SAMP3] = q.samp3;
                    end
                    `CPMBT_OFF_STATUS:
                    begin
                        d.prdata[`CPMBT_ST_ACK] = (q.mode == MODE_SLEEP);
                        d.prdata[`CPMBT_ST_MODE_HI:`CPMBT_ST_MODE_LO] =
                            q.mode;
                        d.prdata[`CPMBT_ST_GRP_HI:`CPMBT_ST_GRP_LO] = q.boGrp;
                    end
                    default:
                    begin
                        d.pslverr = 1'b1;
                    end
                endcase
            end
        end

        if (wrEn)
        begin
            case (paddr)
                `CPMBT_OFF_CTRL0:
                begin
                    d.soft_reset_lock = pwdata[`CPMBT_C0_SOFTRST];
                    d.tlnk = pwdata[`CPMBT_C0_TLINK];
                    if (pwdata[`CPMBT_C0_SLEEP_REQUEST] | (q.mode == MODE_SLEEP))
                    begin
                        d.sleep_request = pwdata[`CPMBT_C0_SLEEP_REQUEST];
                    end
                end
                `CPMBT_OFF_CTRL1:
                begin
                    if (q.soft_reset_lock)
                    begin
                        d.wufs = pwdata[`CPMBT_C1_WUFILT];
                        d.clkSel = pwdata[`CPMBT_C1_CLKSEL];
                    end
                end
                `CPMBT_OFF_BTIM0:
                begin
                    if (q.soft_reset_lock)
                    begin
                        d.presc = pwdata[`CPMBT_B0_PRESC_HI:`CPMBT_B0_PRESC_LO];
                        d.resync_jump_width = pwdata[`CPMBT_B0_SJW_HI:`CPMBT_B0_SJW_LO];
                    end
                end
                `CPMBT_OFF_BTIM1:
                begin
                    if (q.soft_reset_lock)
                    begin
                        d.time_segment_one = pwdata[`CPMBT_B1_TIME_SEGMENT_ONE_HI:`CPMBT_B1_TIME_SEGMENT_ONE_LO];
                        if (d.time_segment_one < 4'h3)
                        begin
                            d.time_segment_one = 4'h3;
                        end
                        d.time_segment_two = pwdata[`CPMBT_B1_TIME_SEGMENT_TWO_HI:`CPMBT_B1_TIME_SEGMENT_TWO_LO];
                        if (d.time_segment_two == 3'h0)
                        begin
                            d.time_segment_two = 3'h1;
                        end
                        d.samp3 = pwdata[`CPMBT_B1_SAMP3];
                    end
                end
                default:
                begin
                end
            endcase
        end

        if (((q.mode == MODE_SLEEP) | pwrDown) & q.wufs & rxDom)
        begin
            if (q.filtCnt != 8'hff)
            begin
                d.filtCnt = q.filtCnt + 8'h01;
            end
        end
        else
        begin
            d.filtCnt = 8'h00;
        end
        if (q.wufs)
        begin
            wakeDet = rxDom & (q.filtCnt >= 8'(`CPMBT_FILT_CYC - 1));
        end
        else
        begin
            wakeDet = rxDom;
        end

        // CPU wait does not alter the mode
        tqRun = (q.mode == MODE_NORMAL) | (q.mode == MODE_SLPPND) |
                (q.mode == MODE_RESYNC);

        srcTick = q.clkSel ? pllTick : xtalTick;
        tq = 1'b0;
        if (!tqRun)
        begin
            d.preCnt = 6'h00;
        end
        else if (srcTick)
        begin
            if (q.preCnt == q.presc)
            begin
                d.preCnt = 6'h00;
                tq = 1'b1;
            end
            else
            begin
                d.preCnt = q.preCnt + 6'h01;
            end
        end

        // bit length from sync and segments
        seg1End = {1'b0, q.time_segment_one} + 5'h1;
        lastIdx = seg1End + {2'b0, q.time_segment_two} + 5'h1;
        sjwLen = {3'b0, q.resync_jump_width} + 5'h1;
        rem = lastIdx - q.tqCnt + 5'h1;
        edgeSeen = q.rxPrev & ~bus_receive_pin;
        bitEnd = tq & (q.tqCnt == lastIdx);
        vote = {1'b0, q.smp[0]} + {1'b0, q.smp[1]} + {1'b0, bus_receive_pin};
        bitVal = q.samp3 ? vote[1] : bus_receive_pin;

        if (!tqRun)
        begin
            d.tqCnt = 5'h00;
            d.resyncUsed = 1'b0;
        end
        else if (tq)
        begin
            d.rxPrev = bus_receive_pin;
            d.tqCnt = q.tqCnt + 5'h01;
            if (edgeSeen & ~q.resyncUsed & (q.tqCnt != 5'h00))
            begin
                d.resyncUsed = 1'b1;
                if (q.tqCnt <= seg1End)
                begin
                    d.tqCnt = (q.tqCnt > sjwLen) ?
                              q.tqCnt - sjwLen + 5'h01 : 5'h01;
                end
                else if (rem <= sjwLen)
                begin
                    d.tqCnt = 5'h01;
                end
                else
                begin
                    d.tqCnt = q.tqCnt + sjwLen;
                end
            end
            if (bitEnd)
            begin
                d.tqCnt = 5'h00;
                d.resyncUsed = 1'b0;
                d.eng.txPoint = 1'b1;
                d.eng.busTx = q.eng.engRun ? engTxBit : 1'b1;
            end
            // samples before and at the point
            if (q.tqCnt == seg1End - 5'h2)
            begin
                d.smp[0] = bus_receive_pin;
            end
            if (q.tqCnt == seg1End - 5'h1)
            begin
                d.smp[1] = bus_receive_pin;
            end
            if (q.tqCnt == seg1End)
            begin
                d.eng.sampleTick = 1'b1;
                d.eng.rxBit = bitVal;
            end
        end

        // bus-off group count, frozen when stopped
        if (!engBusOff)
        begin
            d.boBits = 4'h0;
            d.boGrp = 7'h00;
        end
        else if (q.eng.sampleTick)
        begin
            if (!q.eng.rxBit)
            begin
                d.boBits = 4'h0;
            end
            else if (q.boBits == `CPMBT_SYNC_BITS - 4'h1)
            begin
                d.boBits = 4'h0;
                d.boGrp = q.boGrp + 7'h01;
                if (q.boGrp == `CPMBT_BUSOFF_GRPS)
                begin
                    d.boGrp = 7'h00;
                    d.eng.busOffDone = 1'b1;
                end
            end
            else
            begin
                d.boBits = q.boBits + 4'h1;
            end
        end

        // held from valid frame until the next bit end
        if (engFrameValid)
        begin
            d.pulseOn = 1'b1;
        end
        else if (bitEnd | ~tqRun)
        begin
            d.pulseOn = 1'b0;
        end
        d.eng.timerCap = d.pulseOn & q.tlnk;

        d.recCnt = 4'h0;
        if (cpuStop)
        begin
            if (!pwrDown)
            begin
                d.eng.engAbort = 1'b1;
            end
            d.mode = MODE_PWRDN;
            d.eng.wakeReq = pwrDown & wakeDet;
        end
        else if (q.soft_reset_lock & (q.mode != MODE_SOFTRS))
        begin
            d.eng.engAbort = 1'b1;
            d.mode = MODE_SOFTRS;
        end
        else
        begin
            case (q.mode)
                MODE_NORMAL:
                begin
                    if (q.sleep_request)
                    begin
                        d.mode = MODE_SLPPND;
                    end
                end
                MODE_SLPPND:
                begin
                    if (!engBusy & !engTxPending)
                    begin
                        d.mode = MODE_SLEEP;
                    end
                end
                MODE_SLEEP:
                begin
                    if (wakeDet)
                    begin
                        d.sleep_request = 1'b0;
                        d.eng.wakeReq = 1'b1;
                        d.mode = MODE_RESYNC;
                    end
                    else if (!q.sleep_request)
                    begin
                        d.mode = MODE_RESYNC;
                    end
                end
                MODE_SOFTRS:
                begin
                    if (!q.soft_reset_lock)
                    begin
                        d.mode = MODE_RESYNC;
                    end
                end
                MODE_PWRDN:
                begin
                    d.mode = MODE_RESYNC;
                end
                MODE_RESYNC:
                begin
                    d.recCnt = q.recCnt;
                    if (q.eng.sampleTick)
                    begin
                        d.recCnt = q.eng.rxBit ? q.recCnt + 4'h1 : 4'h0;
                        if (q.eng.rxBit &
                            (q.recCnt == `CPMBT_SYNC_BITS - 4'h1))
                        begin
                            d.eng.deferGo = 1'b1;
                            d.mode = MODE_NORMAL;
                        end
                    end
                end
                default:
                begin
                    d.mode = MODE_SOFTRS;
                end
            endcase
        end

        d.eng.engRun = (d.mode == MODE_NORMAL) | (d.mode == MODE_SLPPND);
        if (!d.eng.engRun)
        begin
            d.eng.busTx = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            q <= '0;
            q.mode <= MODE_SOFTRS;
            q.soft_reset_lock <= `CPMBT_RST_SOFTRST;
            q.presc <= `CPMBT_RST_PRESC;
            q.resync_jump_width <= `CPMBT_RST_SJW;
            q.time_segment_one <= `CPMBT_RST_TIME_SEGMENT_ONE;
            q.time_segment_two <= `CPMBT_RST_TIME_SEGMENT_TWO;
            q.rxPrev <= 1'b1;
            q.eng.busTx <= 1'b1;
            q.eng.rxBit <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end

    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign bus_transmit_pin = q.eng.busTx;
    assign engRun = q.eng.engRun;
    assign engAbort = q.eng.engAbort;
    assign engSampleTick = q.eng.sampleTick;
    assign engRxBit = q.eng.rxBit;
    assign engTxPoint = q.eng.txPoint;
    assign engDeferGo = q.eng.deferGo;
    assign engBusOffDone = q.eng.busOffDone;
    assign wakeReq = q.eng.wakeReq;
    assign timerCapture = q.eng.timerCap;

endmodule

/* File: cpmbt_props.sv */
// Concurrent checks on the ports of the mode control and bit timing block.
module cpmbt_props
(
    input wire logic        core_clk,
    input wire logic        rst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        cpuStop,
    input wire logic        bus_transmit_pin,
    input wire logic        engFrameValid,
    input wire logic        engRun,
    input wire logic        engAbort,
    input wire logic        engDeferGo,
    input wire logic        wakeReq,
    input wire logic        timerCapture
);
    logic [2:0] stopCnt_q;

    // Counts how long the CPU has been stopped, saturating at seven.
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            stopCnt_q <= 3'h0;
        else if (!cpuStop)
            stopCnt_q <= 3'h0;
        else if (stopCnt_q != 3'h7)
            stopCnt_q <= stopCnt_q + 3'h1;
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence firstAccess;
        psel && $rose(penable);
    endsequence
    sequence stopSettled;
        stopCnt_q == 3'h7;
    endsequence

    wait_state_a: assert property (firstAccess |=> pready)
        else $error("pready not one cycle after first access");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    pd_access_a: assert property (stopSettled and pready |-> pslverr && prdata == 32'h0)
        else $error("register answered while powered down");
    pd_recessive_a: assert property (stopSettled |-> bus_transmit_pin && !engRun)
        else $error("transmit pin dominant while powered down");
    stop_halt_a: assert property ($rose(cpuStop) |-> ##[1:2] !engRun)
        else $error("engine still running after CPU stop");
    abort_halt_a: assert property (engAbort |-> ##[0:1] !engRun)
        else $error("engine running after abort");
    cap_cause_a: assert property ($rose(timerCapture) |-> $past(engFrameValid))
        else $error("timer pulse without a valid frame");
    wake_halted_a: assert property (wakeReq |-> !engRun)
        else $error("wake request while engine running");
    defer_run_a: assert property (engDeferGo |-> ##[0:1] engRun)
        else $error("deferred work released without rejoining");
endmodule

bind cpmbt_top cpmbt_props u_props
(
    .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cpuStop(cpuStop),
    .bus_transmit_pin(bus_transmit_pin), .engFrameValid(engFrameValid),
    .engRun(engRun), .engAbort(engAbort), .engDeferGo(engDeferGo),
    .wakeReq(wakeReq), .timerCapture(timerCapture)
);

/* File: cpmbt_bus_model.sv */
// Bus and transceiver: wired-AND of this node and a remote node.
module cpmbt_bus_model
#(
    parameter int LOOP = 1
)
(
    input  wire logic core_clk,
    input  wire logic txPin,
    input  wire logic remoteDom,
    output logic      rxPin
);
    timeunit 1ns;
    timeprecision 100ps;
    logic            tapIn;
    logic [LOOP-1:0] dly;

    // The bus idles recessive through termination; any dominant node wins.
    assign tapIn = txPin & ~remoteDom;
    always @(posedge core_clk)
        dly <= LOOP'({dly, tapIn});
    assign rxPin = dly[LOOP-1];
endmodule

/* File: tb_can_power_modes_bit_timing.sv */
// Self-checking bench for the mode control and bit timing block.
module tb_can_power_modes_bit_timing
    import cpmbt_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic        core_clk, rst_n, psel, penable, pwrite, cpuStop, e, asleep;
    logic        xtalTick, pllTick, remoteDom, txPin, rxPin, pready, pslverr;
    logic        engTxBit, engBusy, engTxPending, engFrameValid, engBusOff;
    logic        engRun, engAbort, engSampleTick, engRxBit, engTxPoint;
    logic        engDeferGo, engBusOffDone, wakeReq, timerCapture;
    logic [7:0]  paddr;
    logic [15:0] lfsr;
    logic [31:0] pwdata, prdata, r;
    logic [31:0] m [5];
    int          mismatches, num_checks, per, capCnt, p, t1, t2, d0;
    int          deferCnt, wakeCnt, abortCnt;

    cpmbt_top dut
    (
        .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cpuStop(cpuStop),
        .xtalTick(xtalTick), .pllTick(pllTick), .bus_receive_pin(rxPin),
        .bus_transmit_pin(txPin), .engTxBit(engTxBit), .engBusy(engBusy),
        .engTxPending(engTxPending), .engFrameValid(engFrameValid),
        .engBusOff(engBusOff), .engRun(engRun), .engAbort(engAbort),
        .engSampleTick(engSampleTick), .engRxBit(engRxBit),
        .engTxPoint(engTxPoint), .engDeferGo(engDeferGo),
        .engBusOffDone(engBusOffDone), .wakeReq(wakeReq),
        .timerCapture(timerCapture)
    );
    cpmbt_bus_model bus
    (
        .core_clk(core_clk), .txPin(txPin), .remoteDom(remoteDom),
        .rxPin(rxPin)
    );

    initial
    begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    // The PLL enable runs at half the oscillator enable rate.
    always @(posedge core_clk)
    begin
        pllTick <= ~pllTick;
        deferCnt += engDeferGo;
        wakeCnt += wakeReq;
        abortCnt += engAbort;
        capCnt += timerCapture;
    end

    function automatic logic [15:0] nxt(logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction

    task automatic chk(string n, logic [31:0] x, logic [31:0] g);
        num_checks++;
        if (g !== x)
        begin
            $display("[FAIL] %s expected %h seen %h", n, x, g);
            mismatches++;
        end
    endtask

    task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge core_clk);
        end
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(logic [7:0] a, logic [31:0] d);
        apb(1'b1, a, d);
        if (a == 8'h00)
            m[0] = {29'h0, d[2:1], d[0] | (m[0][0] & ~asleep)};
        else if (m[0][1])
            m[a[4:2]] = d & (a == 8'h04 ? 32'h3 : 32'hff);
    endtask

    task automatic rd(logic [7:0] a);
        apb(1'b0, a, 32'h0);
        chk("register", m[a[4:2]], r);
        chk("read error", 32'h0, {31'h0, e});
    endtask

    task automatic mode(cpmbt_mode_e md);
        int k;
        k = 0;
        do
        begin
            apb(1'b0, 8'h10, 32'h0);
            k++;
        end
        while (r[6:1] !== md && k < 1500);
        chk("status", {25'h0, md, md == MODE_SLEEP}, {25'h0, r[6:0]});
    endtask

    task automatic bitp();
        while (engTxPoint !== 1'b1 && per < 9999)
        begin
            @(posedge core_clk);
            per++;
        end
        per = 0;
        do
        begin
            @(posedge core_clk);
            per++;
        end
        while (engTxPoint !== 1'b1 && per < 9999);
    endtask

    task automatic pulse();
        @(posedge core_clk);
        engFrameValid <= 1'b1;
        capCnt = 0;
        @(posedge core_clk);
        engFrameValid <= 1'b0;
        repeat (250) @(posedge core_clk);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial
    begin
        #(25 * 60000);
        mismatches++;
        tally_and_finish();
    end

    initial
    begin
        {psel, penable, pwrite, cpuStop, pllTick, remoteDom} = 6'h00;
        {engBusy, engTxPending, engFrameValid, engBusOff, asleep} = 5'h00;
        {paddr, pwdata, rst_n, xtalTick, engTxBit} = 43'h3;
        m = '{32'h2, 32'h0, 32'h0, 32'h13, 32'h0};
        lfsr = 16'h001b;
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 4; i++) rd(8'(i * 4));
        mode(MODE_SOFTRS);
        apb(1'b0, 8'h20, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, e});
        $display("test reset done");
        repeat (5) lfsr = nxt(lfsr);
        p = lfsr[1:0];
        t1 = 3 + lfsr[7:4] % 13;
        t2 = 1 + lfsr[10:8] % 7;
        wr(8'h08, {24'h0, lfsr[15:14], 4'h0, lfsr[1:0]});
        wr(8'h0c, {25'h0, 3'(t2), 4'(t1)});
        wr(8'h04, 32'h2);
        for (int i = 1; i < 4; i++) rd(8'(i * 4));
        wr(8'h00, 32'h0);
        mode(MODE_NORMAL);
        bitp();
        chk("pll bit", 2 * (p + 1) * (t1 + t2 + 3), per);
        engBusy <= 1'b1;
        wr(8'h00, 32'h2);
        mode(MODE_SOFTRS);
        chk("abort", 32'h1, abortCnt);
        engBusy <= 1'b0;
        wr(8'h04, 32'h0);
        wr(8'h00, 32'h0);
        mode(MODE_NORMAL);
        bitp();
        chk("xtal bit", (p + 1) * (t1 + t2 + 3), per);
        $display("test timing done");
        wr(8'h00, 32'h4);
        pulse();
        chk("capture", 32'h1, capCnt >= 1 && capCnt <= per + 1);
        wr(8'h00, 32'h0);
        pulse();
        chk("capture off", 32'h0, capCnt);
        $display("test timer link done");
        engBusy <= 1'b1;
        wr(8'h00, 32'h1);
        mode(MODE_SLPPND);
        wr(8'h00, 32'h0);
        rd(8'h00);
        engBusy <= 1'b0;
        mode(MODE_SLEEP);
        asleep = 1'b1;
        d0 = deferCnt;
        remoteDom <= 1'b1;
        repeat (100) @(posedge core_clk);
        remoteDom <= 1'b0;
        chk("wake", 32'h1, wakeCnt);
        m[0][0] = 1'b0;
        asleep = 1'b0;
        rd(8'h00);
        mode(MODE_NORMAL);
        chk("deferred", d0 + 1, deferCnt);
        $display("test sleep done");
        cpuStop <= 1'b1;
        repeat (8) @(posedge core_clk);
        apb(1'b0, 8'h00, 32'h0);
        chk("pd data", 32'h0, r);
        chk("pd error", 32'h1, {31'h0, e});
        chk("pd tx", 32'h1, {31'h0, txPin});
        cpuStop <= 1'b0;
        mode(MODE_NORMAL);
        $display("test power-down done");
        wr(8'h00, 32'h1);
        mode(MODE_SLEEP);
        wr(8'h00, 32'h3);
        mode(MODE_SOFTRS);
        wr(8'h04, 32'h1);
        wr(8'h00, 32'h1);
        mode(MODE_SLEEP);
        remoteDom <= 1'b1;
        repeat (40) @(posedge core_clk);
        remoteDom <= 1'b0;
        repeat (4) @(posedge core_clk);
        chk("glitch wake", 32'h1, wakeCnt);
        remoteDom <= 1'b1;
        repeat (100) @(posedge core_clk);
        remoteDom <= 1'b0;
        chk("filtered wake", 32'h2, wakeCnt);
        $display("test wake filter done");
        tally_and_finish();
    end
endmodule
